// >>> pkg/boot_cmd_pkg.sv
// boot_cmd_pkg: codes, packet lengths, answer bytes and timing counts
// assumes: byte-wide receive stream from a serial port framer
package boot_cmd_pkg;
    // ==========================================================
    // command codes
    localparam logic [7:0] CMD_SETUP = 8'h21;
    localparam logic [7:0] CMD_RUN = 8'h22;
    localparam logic [7:0] CMD_STATUS = 8'h23;
    localparam logic [7:0] CMD_DATA = 8'h24;
    localparam logic [7:0] CMD_RESET = 8'h25;
    localparam logic [7:0] CMD_PING = 8'h20;
    // ==========================================================
    // packet lengths, counting length and checksum bytes
    localparam logic [7:0] LEN_DATA = 8'h0b;
    localparam logic [7:0] LEN_SETUP = 8'h0b;
    localparam logic [7:0] LEN_RUN = 8'h07;
    localparam logic [7:0] LEN_SHORT = 8'h03;
    localparam logic [7:0] LEN_STATUS_REPLY = 8'h03;
    // ==========================================================
    // answer bytes and status codes
    localparam logic [7:0] ACK_BYTE = 8'hcc;
    localparam logic [7:0] NAK_BYTE = 8'h33;
    localparam logic [7:0] STAT_OK = 8'h40;
    localparam logic [7:0] STAT_FAIL = 8'h43;
    localparam logic [7:0] STAT_BAD_CMD = 8'h41;
    // ==========================================================
    // widths, depths, reset values
    localparam int BYTE_W = 8;
    localparam int FIFO_DEPTH = 4;
    localparam int CHUNK_MAX = 8;
    localparam logic [31:0] ADDR_RST = 32'h0000_0000;
    // ==========================================================
    // timing: pause between acknowledge and jump/reset
    localparam int CLK_HZ = 50_000_000;
    localparam int HANDOFF_NS = 1000;
    localparam int HANDOFF_CYC = (HANDOFF_NS * (CLK_HZ / 1_000_000)) / 1000;
endpackage : boot_cmd_pkg

// >>> logic/byte_fifo.sv
// byte_fifo: small synchronous fifo with valid/ready on both sides
// assumes: one clock, synchronous active-high reset, clock enable
`timescale 1ns/1ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    wire push = ce && in_valid && in_ready;
    wire pop = ce && out_valid && out_ready;
    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    always_ff @(posedge clk) begin
        if (srst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                mem_q[wr_q] <= in_data;
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : byte_fifo

// >>> logic/chunk_mem.sv
// chunk_mem: eight-byte chunk store, registered read port
// assumes: one clock; write and read addresses from the loader
`timescale 1ns/1ps
module chunk_mem (
    input wire logic clk,
    input wire logic ce,
    input wire logic we,
    input wire logic [2:0] wa,
    input wire logic [7:0] wd,
    input wire logic [2:0] ra,
    output logic [7:0] rd
);
    logic [7:0] mem_q [8];
    always_ff @(posedge clk) begin
        if (ce) begin
            if (we) begin
                mem_q[wa] <= wd;
            end
            rd <= mem_q[ra];
        end
    end
endmodule : chunk_mem

// >>> logic/boot_loader.sv
// boot_loader: packet parser and command handler of the serial loader
// assumes: byte stream from a serial port framer on MCLK; flash writer
// takes one byte per FLASH_READY cycle and reports success per byte
//
// Behaviour
// - data-write only while a setup's byte count is still open
// - programming address advances by itself
// - sequence ends after announced byte count
// - rejected chunk leaves address unchanged
// - data-write length 11, checksum bytes 2..10
// - jump carries 32-bit address, msb first
// - acknowledge before jumping
// - jump length 7, checksum bytes 2..6
// - acknowledge before device reset
// - reset command requests full device reset
// - reset packet three bytes, checksum equals command
// - length byte, then checksum of data bytes
// - answer 0xCC acknowledge, 0x33 refusal
// - setup gives 32-bit address and count
// - leading zero bytes are ignored
`timescale 1ns/1ps
module boot_loader
    import boot_cmd_pkg::*;
(
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic CE,
    input wire logic [7:0] RX_DATA,
    input wire logic RX_VALID,
    output logic RX_READY,
    output logic [7:0] TX_DATA,
    output logic TX_VALID,
    input wire logic TX_READY,
    output logic [31:0] FLASH_ADDR,
    output logic [7:0] FLASH_DATA,
    output logic FLASH_WE,
    input wire logic FLASH_READY,
    input wire logic FLASH_OK,
    output logic [31:0] RUN_ADDR,
    output logic RUN_GO,
    output logic RESET_REQ,
    output logic PROG_ACTIVE
);
    typedef enum {
        S_IDLE, S_SUM, S_BODY, S_EXEC, S_ACK, S_WRITE, S_REPLY, S_HOLD
    } state_t;
    typedef enum { H_NONE, H_RUN, H_RESET } handoff_t;

    // ==========================================================
    // input fifo; ready drops for a cycle after each push, so the
    // registered RX_READY never offers room that a push just filled
    logic [7:0] fb;
    logic fv;
    logic fr;
    logic fifo_in_ready;
    logic rx_ready_q;
    wire rx_push = RX_VALID && rx_ready_q;
    byte_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(MCLK),
        .srst(SRST),
        .ce(CE),
        .in_data(RX_DATA),
        .in_valid(rx_push),
        .in_ready(fifo_in_ready),
        .out_data(fb),
        .out_valid(fv),
        .out_ready(fr)
    );

    state_t st_q;
    handoff_t ho_q;
    logic [7:0] len_q;
    logic [7:0] sum_q;
    logic [7:0] acc_q;
    logic [7:0] idx_q;
    logic [7:0] cmd_q;
    logic [63:0] par_q;
    logic [31:0] addr_q;
    logic [31:0] left_q;
    logic seq_q;
    logic ok_q;
    logic good_q;
    logic [7:0] stat_q;
    logic [3:0] wcnt_q;
    logic [3:0] nbytes_q;
    logic [1:0] rep_q;
    logic [15:0] hold_q;
    logic [7:0] tx_q;
    logic txv_q;
    logic we_q;
    logic mem_rd_en_q;
    logic [7:0] mem_rd;
    logic mem_we;
    logic [2:0] mem_wa;

    chunk_mem u_mem (
        .clk(MCLK),
        .ce(CE),
        .we(mem_we),
        .wa(mem_wa),
        .wd(fb),
        .ra(wcnt_q[2:0]),
        .rd(mem_rd)
    );

    // ==========================================================
    // decode
    wire take = fv && fr;
    wire tx_free = !txv_q || TX_READY;
    assign fr = CE && (st_q == S_IDLE || st_q == S_SUM || st_q == S_BODY);
    wire data_idx = (idx_q >= 8'h01) && (idx_q <= 8'h08);
    assign mem_we = take && st_q == S_BODY && cmd_q == CMD_DATA && data_idx;
    assign mem_wa = 3'(idx_q - 8'h01);
    wire [7:0] acc_nx = acc_q + fb;
    wire last = (idx_q == len_q - 8'h03);
    // only data-write, setup, jump and short commands have valid lengths
    wire len_ok = (cmd_q == CMD_DATA && len_q == LEN_DATA)
        || (cmd_q == CMD_SETUP && len_q == LEN_SETUP)
        || (cmd_q == CMD_RUN && len_q == LEN_RUN)
        || ((cmd_q == CMD_RESET || cmd_q == CMD_PING
            || cmd_q == CMD_STATUS) && len_q == LEN_SHORT);
    wire seq_ok = (cmd_q != CMD_DATA) || seq_q;
    wire pkt_ok = good_q && len_ok && seq_ok;
    wire [31:0] chunk = (left_q < 32'(CHUNK_MAX)) ? left_q : 32'(CHUNK_MAX);
    wire [7:0] reply_byte = (rep_q == 2'd0) ? LEN_STATUS_REPLY : stat_q;

    assign RX_READY = rx_ready_q;
    assign TX_DATA = tx_q;
    assign TX_VALID = txv_q;
    assign FLASH_ADDR = addr_q;
    assign FLASH_DATA = mem_rd;
    assign FLASH_WE = we_q;
    assign PROG_ACTIVE = seq_q;

    // ==========================================================
    // packet state machine
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            st_q <= S_IDLE;
            ho_q <= H_NONE;
            len_q <= 8'h00;
            sum_q <= 8'h00;
            acc_q <= 8'h00;
            idx_q <= 8'h00;
            cmd_q <= 8'h00;
            par_q <= 64'h0000_0000_0000_0000;
            addr_q <= ADDR_RST;
            left_q <= 32'h0000_0000;
            seq_q <= 1'b0;
            ok_q <= 1'b0;
            good_q <= 1'b0;
            stat_q <= STAT_OK;
            wcnt_q <= 4'h0;
            nbytes_q <= 4'h0;
            rep_q <= 2'd0;
            hold_q <= 16'h0000;
            tx_q <= 8'h00;
            txv_q <= 1'b0;
            we_q <= 1'b0;
            mem_rd_en_q <= 1'b0;
            rx_ready_q <= 1'b0;
            RUN_ADDR <= 32'h0000_0000;
            RUN_GO <= 1'b0;
            RESET_REQ <= 1'b0;
        end else if (CE) begin
            rx_ready_q <= fifo_in_ready && !rx_push;
            we_q <= 1'b0;
            RUN_GO <= 1'b0;
            if (txv_q && TX_READY) begin
                txv_q <= 1'b0;
            end
            unique case (st_q)
                S_IDLE: if (take && fb != 8'h00) begin
                    len_q <= fb;
                    st_q <= S_SUM;
                end
                S_SUM: if (take) begin
                    sum_q <= fb;
                    // packets shorter than LEN_SHORT skip the body: no stale verdict
                    good_q <= 1'b0;
                    acc_q <= 8'h00;
                    idx_q <= 8'h00;
                    st_q <= (len_q < LEN_SHORT) ? S_EXEC : S_BODY;
                end
                S_BODY: if (take) begin
                    acc_q <= acc_nx;
                    idx_q <= idx_q + 8'h01;
                    if (idx_q == 8'h00) begin
                        cmd_q <= fb;
                    end else begin
                        par_q <= {par_q[55:0], fb};
                    end
                    if (last) begin
                        good_q <= (acc_nx == sum_q);
                        st_q <= S_EXEC;
                    end
                end
                S_EXEC: if (tx_free) begin
                    txv_q <= 1'b1;
                    ok_q <= pkt_ok;
                    tx_q <= pkt_ok ? ACK_BYTE : NAK_BYTE;
                    st_q <= S_ACK;
                    if (pkt_ok) begin
                        unique case (cmd_q)
                            CMD_SETUP: begin
                                addr_q <= par_q[63:32];
                                left_q <= par_q[31:0];
                                seq_q <= (par_q[31:0] != 32'h0000_0000);
                                stat_q <= STAT_OK;
                            end
                            CMD_RUN: begin
                                RUN_ADDR <= par_q[31:0];
                                ho_q <= H_RUN;
                            end
                            CMD_RESET: ho_q <= H_RESET;
                            CMD_PING: stat_q <= STAT_OK;
                            default: ;
                        endcase
                    end else if (good_q && !seq_ok) begin
                        stat_q <= STAT_BAD_CMD;
                    end
                end
                S_ACK: if (tx_free) begin
                    // acknowledge has gone out before any handoff
                    hold_q <= 16'(HANDOFF_CYC);
                    if (ho_q != H_NONE) begin
                        st_q <= S_HOLD;
                    end else if (ok_q && cmd_q == CMD_DATA) begin
                        wcnt_q <= 4'h0;
                        nbytes_q <= 4'(chunk);
                        mem_rd_en_q <= 1'b0;
                        ok_q <= 1'b1;
                        st_q <= S_WRITE;
                    end else if (ok_q && cmd_q == CMD_STATUS) begin
                        rep_q <= 2'd0;
                        st_q <= S_REPLY;
                    end else begin
                        st_q <= S_IDLE; // refusal keeps address
                    end
                end
                S_WRITE: if (wcnt_q == nbytes_q) begin
                    left_q <= left_q - 32'(nbytes_q);
                    if (left_q == 32'(nbytes_q)) begin
                        seq_q <= 1'b0;
                    end
                    stat_q <= ok_q ? STAT_OK : STAT_FAIL;
                    st_q <= S_IDLE;
                end else if (FLASH_READY && !we_q) begin
                    // memory read is registered: one cycle to fetch
                    if (mem_rd_en_q) begin
                        we_q <= 1'b1;
                        mem_rd_en_q <= 1'b0;
                    end else if (!we_q) begin
                        mem_rd_en_q <= 1'b1;
                    end
                end else if (we_q) begin
                    addr_q <= addr_q + 32'h0000_0001;
                    wcnt_q <= wcnt_q + 4'h1;
                    ok_q <= ok_q && FLASH_OK;
                end
                S_REPLY: if (tx_free) begin
                    // reply packet: length, checksum, status byte
                    txv_q <= 1'b1;
                    tx_q <= reply_byte;
                    rep_q <= rep_q + 2'd1;
                    if (rep_q == 2'd2) begin
                        st_q <= S_IDLE;
                    end
                end
                S_HOLD: if (hold_q != 16'h0000) begin
                    hold_q <= hold_q - 16'h0001;
                end else begin
                    RUN_GO <= (ho_q == H_RUN);
                    RESET_REQ <= (ho_q == H_RESET);
                    ho_q <= H_NONE;
                    st_q <= S_IDLE;
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

    // ==========================================================
    // checks
    a_ack_before_go: assert property (
        @(posedge MCLK) disable iff (SRST)
        $rose(RUN_GO) |-> !TX_VALID)
        else $error("jump issued before acknowledge left");
    a_reset_after_ack: assert property (
        @(posedge MCLK) disable iff (SRST)
        $rose(RESET_REQ) |-> $past(st_q) == S_HOLD)
        else $error("reset requested without acknowledge phase");
    a_nak_keeps_addr: assert property (
        @(posedge MCLK) disable iff (SRST)
        (st_q == S_EXEC && CE && tx_free && !pkt_ok) |=> $stable(addr_q))
        else $error("refused packet moved the address");
    a_nak_byte: assert property (
        @(posedge MCLK) disable iff (SRST)
        (st_q == S_EXEC && CE && tx_free && !good_q) |=> tx_q == NAK_BYTE)
        else $error("bad checksum not refused");
    a_zero_skipped: assert property (
        @(posedge MCLK) disable iff (SRST)
        (st_q == S_IDLE && take && fb == 8'h00) |=> st_q == S_IDLE)
        else $error("zero padding started a packet");
    a_addr_step: assert property (
        @(posedge MCLK) disable iff (SRST)
        (st_q == S_WRITE && CE && we_q && wcnt_q != nbytes_q)
        |=> addr_q == $past(addr_q) + 32'h0000_0001)
        else $error("address did not advance by one");
    a_seq_gate: assert property (
        @(posedge MCLK) disable iff (SRST)
        (st_q == S_EXEC && cmd_q == CMD_DATA && !seq_q && CE && tx_free)
        |=> tx_q == NAK_BYTE)
        else $error("data-write outside a sequence accepted");
    a_seq_end: assert property (
        @(posedge MCLK) disable iff (SRST)
        (st_q == S_WRITE && CE && wcnt_q == nbytes_q
            && left_q == 32'(nbytes_q)) |=> !seq_q)
        else $error("sequence did not end at byte count");
    a_status_kept: assert property (
        @(posedge MCLK) disable iff (SRST)
        (st_q == S_WRITE && CE && wcnt_q == nbytes_q && !ok_q)
        |=> stat_q == STAT_FAIL)
        else $error("failed chunk not recorded");
    c_jump: cover property (@(posedge MCLK) RUN_GO);
    c_reset: cover property (@(posedge MCLK) RESET_REQ);
    c_chunk: cover property (@(posedge MCLK) st_q == S_WRITE && we_q);
    c_nak: cover property (@(posedge MCLK) txv_q && tx_q == NAK_BYTE);
endmodule : boot_loader

// >>> testbench/host_model.sv
// host_model: host end of the loader's byte link, driven by task calls
// assumes: one clock; bytes change on its falling edge only
`timescale 1ns/1ps
module host_model (
    input wire logic clk,
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready
);
    bit timed_out = 0;

    initial begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
        tx_ready = 1'b1;
    end

    // ==========================================================
    // sending: ready is a late copy, so one idle cycle per byte
    task send_byte(input logic [7:0] b);
        int n;
        n = 0;
        @(negedge clk);
        rx_data = b;
        rx_valid = 1'b1;
        while (rx_ready !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        if (n == 300)
            timed_out = 1;
        @(negedge clk);
        rx_valid = 1'b0;
        rx_data = ~b; // released line must not repeat the byte
    endtask : send_byte

    task send_pkt(input logic [7:0] p[$]);
        foreach (p[i])
            send_byte(p[i]);
    endtask : send_pkt

    // ==========================================================
    // receiving: optional stall, leading zero bytes skipped
    task get_byte(input int slow, output logic [7:0] b);
        int n;
        b = 8'hxx;
        if (slow > 0) begin
            tx_ready = 1'b0;
            repeat (slow) @(negedge clk);
            tx_ready = 1'b1;
        end
        for (n = 0; n < 300; n++) begin
            // look before waiting: a standing byte leaves at the next edge
            if (tx_valid === 1'b1 && tx_data !== 8'h00) begin
                b = tx_data;
                @(negedge clk);
                return;
            end
            @(negedge clk);
        end
        timed_out = 1;
    endtask : get_byte
endmodule : host_model

// >>> testbench/boot_loader_test.sv
// boot_loader_test: scenario bench for the serial loader command handler
// assumes: host_model on the byte link; flash writer modelled here
`timescale 1ns/1ps
module boot_loader_test
    import boot_cmd_pkg::*;
;
    logic mclk = 0;
    logic srst = 1;
    logic flash_ready = 0;
    logic flash_ok = 1;
    logic [7:0] rx_data, tx_data, flash_data;
    logic rx_valid, rx_ready, tx_valid, tx_ready, flash_we;
    logic [31:0] flash_addr, run_addr;
    logic run_go, reset_req, prog_active;
    int err_total = 0;
    int checked = 0;
    int go_n = 0;
    logic [39:0] wq[$];

    initial forever #10 mclk = ~mclk;
    // slow flash writer: ready every other cycle
    always @(negedge mclk) flash_ready <= ~flash_ready;
    always @(posedge mclk) begin
        if (flash_we === 1'b1)
            wq.push_back({flash_addr, flash_data});
        if (run_go === 1'b1)
            go_n++;
    end

    boot_loader boot_loader_i (
        .MCLK(mclk), .SRST(srst), .CE(1'b1),
        .RX_DATA(rx_data), .RX_VALID(rx_valid), .RX_READY(rx_ready),
        .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready),
        .FLASH_ADDR(flash_addr), .FLASH_DATA(flash_data),
        .FLASH_WE(flash_we), .FLASH_READY(flash_ready), .FLASH_OK(flash_ok),
        .RUN_ADDR(run_addr), .RUN_GO(run_go), .RESET_REQ(reset_req),
        .PROG_ACTIVE(prog_active)
    );

    host_model host_model_i (
        .clk(mclk), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready)
    );

    // ==========================================================
    // shared checking and link tasks
    task tally_and_finish;
        $display("errors %0d checks %0d", err_total, checked);
        if (err_total == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish

    task check(input logic [39:0] got, exp, input string what);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: %s got %h", $time, what, got);
        end
    endtask : check

    task guard;
        if (host_model_i.timed_out) begin
            err_total++;
            $display("unexpected at %0t: link wait ran out", $time);
            tally_and_finish;
        end
    endtask : guard

    // skew nonzero spoils the checksum on purpose
    task send_cmd(input logic [7:0] d[$], input logic [7:0] skew);
        logic [7:0] cs;
        logic [7:0] p[$];
        cs = skew;
        foreach (d[i])
            cs += d[i];
        p = d;
        p.push_front(cs);
        p.push_front(8'(d.size() + 2));
        host_model_i.send_pkt(p);
        guard;
    endtask : send_cmd

    task expect_byte(input logic [7:0] exp, input int slow, string what);
        logic [7:0] b;
        host_model_i.get_byte(slow, b);
        guard;
        check({32'h0, b}, {32'h0, exp}, what);
    endtask : expect_byte

    task chunk(input logic [7:0] base, skew, input int n,
               input logic [31:0] at, input logic [7:0] ans);
        int i;
        logic [7:0] d[$];
        d = '{CMD_DATA};
        for (i = 0; i < 8; i++)
            d.push_back(base + 8'(i));
        wq = {};
        send_cmd(d, skew);
        expect_byte(ans, 3, "chunk answer");
        for (i = 0; i < 80 && wq.size() <= n; i++)
            @(negedge mclk);
        check(40'(wq.size()), 40'(n), "write count");
        foreach (wq[j])
            check(wq[j], {at + 32'(j), base + 8'(j)}, "flash write");
    endtask : chunk

    // ==========================================================
    // scenarios
    task sc_ping;
        host_model_i.send_byte(8'h00);
        host_model_i.send_byte(8'h00);
        send_cmd('{CMD_PING}, 8'h00);
        expect_byte(ACK_BYTE, 5, "ping answer");
        send_cmd('{CMD_PING}, 8'h01);
        expect_byte(NAK_BYTE, 0, "bad sum answer");
    endtask : sc_ping

    task sc_program;
        send_cmd('{CMD_SETUP, 8'h00, 8'h00, 8'h10, 8'h00,
                   8'h00, 8'h00, 8'h00, 8'h0c}, 8'h00);
        expect_byte(ACK_BYTE, 0, "setup answer");
        check({39'h0, prog_active}, 40'h1, "sequence open");
        chunk(8'h10, 8'h00, 8, 32'h0000_1000, ACK_BYTE);
        chunk(8'h20, 8'h01, 0, 32'h0000_1008, NAK_BYTE);
        chunk(8'h20, 8'h00, 4, 32'h0000_1008, ACK_BYTE);
        check({39'h0, prog_active}, 40'h0, "sequence end");
        chunk(8'h30, 8'h00, 0, 32'h0000_0000, NAK_BYTE);
    endtask : sc_program

    // flash writer refuses every byte: the status must say so
    task sc_fail;
        send_cmd('{CMD_SETUP, 8'h00, 8'h00, 8'h20, 8'h00,
                   8'h00, 8'h00, 8'h00, 8'h04}, 8'h00);
        expect_byte(ACK_BYTE, 0, "setup answer");
        flash_ok = 1'b0;
        chunk(8'h50, 8'h00, 4, 32'h0000_2000, ACK_BYTE);
        flash_ok = 1'b1;
        check({39'h0, prog_active}, 40'h0, "short end");
        send_cmd('{CMD_STATUS}, 8'h00);
        expect_byte(ACK_BYTE, 0, "status answer");
        expect_byte(LEN_STATUS_REPLY, 0, "reply length");
        expect_byte(STAT_FAIL, 0, "fail sum");
        expect_byte(STAT_FAIL, 0, "fail status");
    endtask : sc_fail

    task sc_run;
        int i;
        go_n = 0;
        send_cmd('{CMD_RUN, 8'h12, 8'h34, 8'h56, 8'h78}, 8'h00);
        expect_byte(ACK_BYTE, 0, "jump answer");
        check(40'(go_n), 40'h0, "jump before answer");
        for (i = 0; i < 100 && run_go !== 1'b1; i++)
            @(negedge mclk);
        check({39'h0, run_go}, 40'h1, "jump pulse");
        check({8'h0, run_addr}, 40'h12_3456_78, "jump address");
        check(40'(i > HANDOFF_CYC - 4 && i < HANDOFF_CYC + 4), 40'h1,
              "jump delay");
    endtask : sc_run

    task sc_reset;
        int i;
        send_cmd('{CMD_RESET}, 8'h00);
        expect_byte(ACK_BYTE, 0, "reset answer");
        check({39'h0, reset_req}, 40'h0, "reset before answer");
        for (i = 0; i < 100 && reset_req !== 1'b1; i++)
            @(negedge mclk);
        check({39'h0, reset_req}, 40'h1, "reset request");
        srst = 1'b1;
        @(negedge mclk);
        srst = 1'b0;
        check({39'h0, reset_req}, 40'h0, "reset cleared");
        repeat (2) @(negedge mclk);
    endtask : sc_reset

    task sc_status;
        chunk(8'h40, 8'h00, 0, 32'h0000_0000, NAK_BYTE);
        send_cmd('{CMD_STATUS}, 8'h00);
        expect_byte(ACK_BYTE, 0, "status answer");
        expect_byte(LEN_STATUS_REPLY, 2, "reply length");
        expect_byte(STAT_BAD_CMD, 0, "reply sum");
        expect_byte(STAT_BAD_CMD, 4, "reply status");
        host_model_i.send_byte(ACK_BYTE);
    endtask : sc_status

    initial begin
        repeat (8) @(negedge mclk);
        srst = 1'b0;
        repeat (2) @(negedge mclk);
        sc_ping;
        sc_program;
        sc_fail;
        sc_run;
        sc_reset;
        sc_status;
        tally_and_finish;
    end
endmodule : boot_loader_test
